// ==== logic/l2cp_consts.svh ====
// Named offsets, reset values and fixed sizes of the cache policy block.
// Assumes it is included by bare name wherever a constant is needed.
`ifndef L2CP_CONSTS_SVH
`define L2CP_CONSTS_SVH
`define L2CP_A_CTRL     8'h00
`define L2CP_A_ESTAT    8'h04
`define L2CP_A_EADDR    8'h08
`define L2CP_A_EMASK    8'h0c
`define L2CP_A_SCTRL    8'h10
`define L2CP_A_SDLY     8'h14
`define L2CP_A_RNG      2'h1
`define L2CP_CTRL_RST   32'h0000_0000
`define L2CP_SDLY_RST   16'h0100
`define L2CP_LFSR_SEED  8'h5a
`define L2CP_NRNG       16
`define L2CP_WAYS       4
`define L2CP_WAY_KIB    64
`define L2CP_LINE_B     32
`define L2CP_CW_LEN     38
`define L2CP_WIN_CFG    12'hf08
`define L2CP_WIN_PNP    12'hffe
`define L2CP_HP_C       3
`define L2CP_HP_B       2
`define L2CP_OKAY       2'h0
`define L2CP_SLVERR     2'h2
`endif

// ==== logic/l2cp_pkg.sv ====
// Types shared by the cache policy, protection and scrub logic.
// Assumes a 32-bit processor-side address.
package l2cp_pkg;
  typedef enum logic [1:0] {REPL_LRU = 2'h0, REPL_RAND = 2'h1,
    REPL_MFIX = 2'h2, REPL_MMOD = 2'h3} l2cp_repl_t;
  typedef enum logic [1:0] {ET_CE = 2'h0, ET_UE = 2'h1,
    ET_WP = 2'h2, ET_BE = 2'h3} l2cp_etype_t;
  typedef enum logic [1:0] {RT_UNC = 2'h0, RT_WT = 2'h1,
    RT_WP = 2'h2, RT_NONE = 2'h3} l2cp_rtype_t;
  typedef enum logic [1:0] {RSP_OK = 2'h0, RSP_ERR = 2'h1,
    RSP_RETRY = 2'h2} l2cp_resp_t;
  typedef enum logic [1:0] {ACT_NONE = 2'h0, ACT_FIX = 2'h1,
    ACT_INVAL = 2'h2, ACT_REFETCH = 2'h3} l2cp_act_t;
  typedef enum logic [1:0] {WIN_NONE = 2'h0, WIN_DATA = 2'h1,
    WIN_CFG = 2'h2, WIN_PNP = 2'h3} l2cp_win_t;
  typedef enum logic [1:0] {S_IDLE = 2'h0, S_REQ = 2'h1,
    S_DLY = 2'h2} l2cp_sst_t;
  typedef struct packed {
    logic [19:0] rsv; logic [1:0] locked; logic [1:0] ovf_way;
    l2cp_repl_t repl; logic err_resp; logic wt; logic rhb;
    logic hprot_en; logic edac_en; logic en;
  } l2cp_ctrl_t;
  typedef struct packed {
    logic [13:0] addr; l2cp_rtype_t rtype; logic [13:0] mask;
    logic rsv; logic en;
  } l2cp_rng_t;
  typedef struct packed {
    logic [7:0] ce_cnt; logic [16:0] rsv; logic valid;
    l2cp_etype_t etype; logic [3:0] pend;
  } l2cp_estat_t;
  typedef struct packed {
    logic [4:0] rsv0; logic [10:0] idx; logic [11:0] rsv1;
    logic [1:0] way; logic en; logic pend;
  } l2cp_sctrl_t;
  typedef struct packed {
    logic [15:0] tag; logic [5:0] zero; logic [1:0] valid;
    logic [1:0] dirty; logic rsv; logic [4:0] lru;
  } l2cp_tag_t;
  typedef struct packed {
    logic awvalid; logic [11:0] awaddr; logic wvalid;
    logic [31:0] wdata; logic [3:0] wstrb; logic bready;
    logic arvalid; logic [11:0] araddr; logic rready;
  } l2cp_axi_req_t;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata;
    logic [1:0] rresp;
  } l2cp_axi_rsp_t;
  typedef struct packed {
    logic valid; logic write; logic [31:0] addr; logic [3:0] mst;
    logic [3:0] hprot; logic hit; logic [1:0] lru_way;
    logic [3:0] vd0; logic [3:0] vd1; logic [3:0] vd2;
  } l2cp_acc_req_t;
  typedef struct packed {
    logic valid; l2cp_win_t win; logic cachable; logic bufferable;
    logic mem; logic cache_upd; logic alloc; logic wt;
    l2cp_resp_t resp; logic [1:0] way; logic [3:0] vd;
    l2cp_tag_t new_tag;
  } l2cp_acc_dec_t;
  typedef struct packed {
    logic valid; logic is_tag; logic write; logic narrow;
    logic dirty; logic [31:0] addr; logic [31:0] data;
    logic [6:0] chk;
  } l2cp_ecc_req_t;
  typedef struct packed {
    logic valid; l2cp_act_t act; l2cp_resp_t resp;
    logic [31:0] data; logic [6:0] chk;
  } l2cp_ecc_res_t;
  typedef struct packed {
    logic valid; logic [10:0] idx; logic [1:0] way;
  } l2cp_scrub_t;
  typedef struct packed {
    l2cp_ctrl_t ctrl; logic [3:0] emask; logic [31:0] eaddr;
    l2cp_estat_t estat; l2cp_sctrl_t sctrl; logic [15:0] sdly;
    l2cp_rng_t [15:0] rng; logic bvalid; logic [1:0] bresp;
    logic rvalid; logic [1:0] rresp; logic [31:0] rdata;
    l2cp_acc_dec_t dec; l2cp_ecc_res_t ecc; logic [7:0] lfsr;
    l2cp_sst_t sst; logic [10:0] sidx; logic [1:0] sway;
    logic [15:0] scnt; logic sone;
  } l2cp_st_t;
endpackage : l2cp_pkg

// ==== logic/l2cp_top.sv ====
// Policy, protection and scrub control of a four-way level-2 cache.
// Assumes one clock, an AXI4-Lite master and a cache datapath that
// supplies lookup results, code words and scrub completions.
`timescale 1ns/1ps
`include "l2cp_consts.svh"
module l2cp_top (
  input  wire logic                    clk_in,
  input  wire logic                    srst_in,
  input  wire l2cp_pkg::l2cp_axi_req_t axi_in,
  output l2cp_pkg::l2cp_axi_rsp_t      axi_out,
  input  wire l2cp_pkg::l2cp_acc_req_t acc_in,
  output l2cp_pkg::l2cp_acc_dec_t      dec_out,
  input  wire l2cp_pkg::l2cp_ecc_req_t ecc_in,
  output l2cp_pkg::l2cp_ecc_res_t      ecc_out,
  input  wire logic                    bus_err_in,
  input  wire logic [31:0]             bus_err_addr_in,
  input  wire logic                    flush_busy_in,
  output l2cp_pkg::l2cp_scrub_t        scrub_out,
  input  wire logic                    scrub_done_in,
  output logic                         irq_out
);
  localparam int IDXW = $clog2(`L2CP_WAY_KIB * 1024 / `L2CP_LINE_B);

  l2cp_pkg::l2cp_st_t    r_reg;
  l2cp_pkg::l2cp_st_t    r_next;
  logic                  aw_go;
  logic                  ar_go;
  logic                  rh;
  l2cp_pkg::l2cp_rtype_t rt;
  l2cp_pkg::l2cp_win_t   win;
  logic                  cach;
  logic                  hitu;
  logic                  wp;
  logic [2:0]            unl;
  logic [4:0]            m1;
  logic [5:0]            syn;
  logic                  par;
  logic                  e_ce;
  logic                  e_ue;
  logic                  ev_ce;
  logic                  ev_ue;
  l2cp_pkg::l2cp_estat_t wv;
  logic [31:0]           fixd;

  // Data bit k sits at the k-th code position that is no power of two.
  function automatic logic [5:0] hgen(input logic [31:0] d);
    logic [5:0] h;
    int         k;
    h = '0;
    k = 0;
    for (int p = 3; p <= `L2CP_CW_LEN; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (d[k]) h = h ^ 6'(p);
        k++;
      end
    end
    return h;
  endfunction : hgen

  function automatic logic [31:0] hfix(input logic [31:0] d,
                                       input logic [5:0]  s);
    logic [31:0] o;
    int          k;
    o = d;
    k = 0;
    for (int p = 3; p <= `L2CP_CW_LEN; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (6'(p) == s) o[k] = ~d[k];
        k++;
      end
    end
    return o;
  endfunction : hfix

  function automatic logic [6:0] cgen(input logic [31:0] d);
    logic [5:0] h;
    h = hgen(d);
    return {^d ^ ^h, h};
  endfunction : cgen

  function automatic logic [31:0] wm(input logic [31:0] o,
                                     input logic [31:0] d,
                                     input logic [3:0]  s);
    logic [31:0] v;
    v = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) v[8*b +: 8] = d[8*b +: 8];
    end
    return v;
  endfunction : wm

  function automatic logic reg_ok(input logic [11:0] a);
    return a[11:8] == 4'h0 && a[1:0] == 2'h0 &&
      (a[7:6] == `L2CP_A_RNG || a[7:0] <= `L2CP_A_SDLY);
  endfunction : reg_ok

  always_comb begin
    r_next = r_reg;
    // Register bus handshakes.
    aw_go = axi_in.awvalid && axi_in.wvalid && !r_reg.bvalid;
    ar_go = axi_in.arvalid && !r_reg.rvalid;
    if (r_reg.bvalid && axi_in.bready) r_next.bvalid = 1'b0;
    if (r_reg.rvalid && axi_in.rready) r_next.rvalid = 1'b0;
    r_next.lfsr = {r_reg.lfsr[6:0],
      r_reg.lfsr[7] ^ r_reg.lfsr[5] ^ r_reg.lfsr[4] ^ r_reg.lfsr[3]};

    // Address-range lookup; the lowest matching entry wins.
    rh = 1'b0;
    rt = l2cp_pkg::RT_NONE;
    for (int i = `L2CP_NRNG - 1; i >= 0; i--) begin
      if (r_reg.rng[i].en && ((r_reg.rng[i].addr ^ acc_in.addr[31:18])
          & r_reg.rng[i].mask) == '0) begin
        rh = 1'b1;
        rt = r_reg.rng[i].rtype;
      end
    end
    if (!acc_in.addr[31]) win = l2cp_pkg::WIN_DATA;
    else if (acc_in.addr[31:20] == `L2CP_WIN_CFG) win = l2cp_pkg::WIN_CFG;
    else if (acc_in.addr[31:20] == `L2CP_WIN_PNP) win = l2cp_pkg::WIN_PNP;
    else win = l2cp_pkg::WIN_NONE;
    cach = win == l2cp_pkg::WIN_DATA && r_reg.ctrl.en &&
      !(rh && rt == l2cp_pkg::RT_UNC) &&
      !(r_reg.ctrl.hprot_en && !acc_in.hprot[`L2CP_HP_C]);
    hitu = acc_in.hit && r_reg.ctrl.en && win == l2cp_pkg::WIN_DATA;
    wp = acc_in.valid && acc_in.write && win == l2cp_pkg::WIN_DATA &&
      rh && rt == l2cp_pkg::RT_WP;

    r_next.dec.valid = acc_in.valid;
    r_next.dec.win = win;
    r_next.dec.cachable = cach;
    r_next.dec.bufferable = acc_in.hprot[`L2CP_HP_B];
    r_next.dec.wt = cach && (r_reg.ctrl.wt || (rh && rt == l2cp_pkg::RT_WT));
    r_next.dec.alloc = cach && !hitu;
    r_next.dec.cache_upd = acc_in.write && (cach || hitu);
    if (win != l2cp_pkg::WIN_DATA || wp) r_next.dec.mem = 1'b0;
    else if (cach) r_next.dec.mem = !hitu || (acc_in.write && r_next.dec.wt);
    else r_next.dec.mem = !hitu || (!acc_in.hprot[`L2CP_HP_B] &&
      (acc_in.write || r_reg.ctrl.rhb));

    // Victim way; locked ways are the uppermost ones.
    unl = 3'(`L2CP_WAYS) - {1'b0, r_reg.ctrl.locked};
    m1 = {1'b0, acc_in.mst} + 5'h1;
    unique case (r_reg.ctrl.repl)
      l2cp_pkg::REPL_LRU:
        r_next.dec.way = ({1'b0, acc_in.lru_way} < unl) ?
          acc_in.lru_way : 2'(unl - 3'h1);
      l2cp_pkg::REPL_RAND:
        r_next.dec.way = 2'({1'b0, r_reg.lfsr[1:0]} % unl);
      l2cp_pkg::REPL_MFIX, l2cp_pkg::REPL_MMOD: begin
        if (m1 < 5'(`L2CP_WAYS)) r_next.dec.way = m1[1:0];
        else if (r_reg.ctrl.repl == l2cp_pkg::REPL_MFIX)
          r_next.dec.way = r_reg.ctrl.ovf_way;
        else r_next.dec.way = 2'(32'(acc_in.mst) % `L2CP_WAYS);
      end
    endcase
    r_next.dec.vd = (acc_in.vd0 & acc_in.vd1) | (acc_in.vd0 & acc_in.vd2)
      | (acc_in.vd1 & acc_in.vd2);
    r_next.dec.new_tag = '0;
    r_next.dec.new_tag.tag = acc_in.addr[31:16];
    r_next.dec.new_tag.valid = 2'h3;
    r_next.dec.new_tag.dirty = {2{acc_in.write && !r_next.dec.wt}};
    if (flush_busy_in) r_next.dec.resp = l2cp_pkg::RSP_RETRY;
    else if (win == l2cp_pkg::WIN_NONE || wp ||
        (r_reg.ctrl.err_resp && r_reg.estat.valid &&
         acc_in.addr[31:5] == r_reg.eaddr[31:5]))
      r_next.dec.resp = l2cp_pkg::RSP_ERR;
    else r_next.dec.resp = l2cp_pkg::RSP_OK;

    // Code word check and the action it calls for.
    syn = ecc_in.chk[5:0] ^ hgen(ecc_in.data);
    par = ^{ecc_in.data, ecc_in.chk};
    e_ce = ecc_in.valid && r_reg.ctrl.edac_en && par;
    e_ue = ecc_in.valid && r_reg.ctrl.edac_en && !par && syn != '0;
    fixd = e_ce ? hfix(ecc_in.data, syn) : ecc_in.data;
    r_next.ecc.valid = ecc_in.valid;
    r_next.ecc.data = fixd;
    r_next.ecc.chk = cgen(fixd);
    r_next.ecc.resp = l2cp_pkg::RSP_OK;
    if (e_ce) r_next.ecc.act = l2cp_pkg::ACT_FIX;
    else if (!e_ue) r_next.ecc.act = l2cp_pkg::ACT_NONE;
    else if (!ecc_in.is_tag && ecc_in.write && ecc_in.narrow &&
        !ecc_in.dirty) r_next.ecc.act = l2cp_pkg::ACT_REFETCH;
    else r_next.ecc.act = l2cp_pkg::ACT_INVAL;
    if (e_ue && !ecc_in.is_tag && !ecc_in.write)
      r_next.ecc.resp = ecc_in.dirty ? l2cp_pkg::RSP_ERR :
        l2cp_pkg::RSP_RETRY;
    ev_ue = e_ue && ecc_in.dirty;
    ev_ce = e_ce || (e_ue && !ecc_in.dirty);

    // Scrubber sequencing.
    unique case (r_reg.sst)
      l2cp_pkg::S_IDLE: begin
        if (r_reg.sctrl.pend) begin
          r_next.sidx = r_reg.sctrl.idx;
          r_next.sway = r_reg.sctrl.way;
          r_next.sone = 1'b1;
          r_next.sst = l2cp_pkg::S_REQ;
        end else if (r_reg.sctrl.en) begin
          r_next.sone = 1'b0;
          r_next.sst = l2cp_pkg::S_REQ;
        end
      end
      l2cp_pkg::S_REQ: begin
        if (scrub_done_in && r_reg.sone) begin
          r_next.sctrl.pend = 1'b0;
          r_next.sst = l2cp_pkg::S_IDLE;
        end else if (scrub_done_in) begin
          {r_next.sidx, r_next.sway} =
            (IDXW + 2)'({r_reg.sidx, r_reg.sway} + 1'b1);
          r_next.scnt = '0;
          r_next.sst = l2cp_pkg::S_DLY;
        end
      end
      l2cp_pkg::S_DLY: begin
        if (r_reg.scnt >= r_reg.sdly || !r_reg.sctrl.en)
          r_next.sst = l2cp_pkg::S_IDLE;
        else r_next.scnt = r_reg.scnt + 16'h1;
      end
      default: r_next.sst = l2cp_pkg::S_IDLE;
    endcase

    // Register writes; hardware-cleared bits were handled above.
    wv = wm(32'h0, axi_in.wdata, axi_in.wstrb);
    if (aw_go) begin
      r_next.bvalid = 1'b1;
      r_next.bresp = reg_ok(axi_in.awaddr) ? `L2CP_OKAY : `L2CP_SLVERR;
      if (axi_in.awaddr[7:6] == `L2CP_A_RNG && reg_ok(axi_in.awaddr))
        r_next.rng[axi_in.awaddr[5:2]] = l2cp_pkg::l2cp_rng_t'(wm(
          r_reg.rng[axi_in.awaddr[5:2]], axi_in.wdata, axi_in.wstrb));
      else if (reg_ok(axi_in.awaddr)) begin
        unique case (axi_in.awaddr[7:0])
          `L2CP_A_CTRL: r_next.ctrl = l2cp_pkg::l2cp_ctrl_t'(
            wm(r_reg.ctrl, axi_in.wdata, axi_in.wstrb));
          `L2CP_A_ESTAT: begin
            r_next.estat.pend = r_reg.estat.pend & ~wv.pend;
            if (wv.valid) begin
              r_next.estat.valid = 1'b0;
              r_next.estat.ce_cnt = '0;
            end
          end
          `L2CP_A_EMASK: r_next.emask = wv[3:0];
          `L2CP_A_SCTRL: r_next.sctrl = l2cp_pkg::l2cp_sctrl_t'(
            wm(r_reg.sctrl, axi_in.wdata, axi_in.wstrb));
          `L2CP_A_SDLY: r_next.sdly = 16'(wm(32'(r_reg.sdly),
            axi_in.wdata, axi_in.wstrb));
          default: ;
        endcase
      end
      r_next.ctrl.rsv = '0;
      r_next.sctrl.rsv0 = '0;
      r_next.sctrl.rsv1 = '0;
      r_next.rng[axi_in.awaddr[5:2]].rsv = 1'b0;
    end

    // Error capture after the clears, so a new event is never lost.
    r_next.estat.pend[l2cp_pkg::ET_CE] |= ev_ce;
    r_next.estat.pend[l2cp_pkg::ET_UE] |= ev_ue;
    r_next.estat.pend[l2cp_pkg::ET_WP] |= wp;
    r_next.estat.pend[l2cp_pkg::ET_BE] |= bus_err_in;
    if (ev_ce && r_next.estat.ce_cnt != 8'hff)
      r_next.estat.ce_cnt = r_next.estat.ce_cnt + 8'h1;
    if (ev_ue) begin
      r_next.estat.valid = 1'b1;
      r_next.estat.etype = l2cp_pkg::ET_UE;
      r_next.eaddr = ecc_in.addr;
    end else if (!r_next.estat.valid && (ev_ce || wp || bus_err_in)) begin
      r_next.estat.valid = 1'b1;
      if (ev_ce) begin
        r_next.estat.etype = l2cp_pkg::ET_CE;
        r_next.eaddr = ecc_in.addr;
      end else if (wp) begin
        r_next.estat.etype = l2cp_pkg::ET_WP;
        r_next.eaddr = acc_in.addr;
      end else begin
        r_next.estat.etype = l2cp_pkg::ET_BE;
        r_next.eaddr = bus_err_addr_in;
      end
    end

    // Register reads.
    if (ar_go) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = reg_ok(axi_in.araddr) ? `L2CP_OKAY : `L2CP_SLVERR;
      r_next.rdata = '0;
      if (axi_in.araddr[7:6] == `L2CP_A_RNG && reg_ok(axi_in.araddr))
        r_next.rdata = r_reg.rng[axi_in.araddr[5:2]];
      else if (reg_ok(axi_in.araddr)) begin
        unique case (axi_in.araddr[7:0])
          `L2CP_A_CTRL:  r_next.rdata = r_reg.ctrl;
          `L2CP_A_ESTAT: r_next.rdata = r_reg.estat;
          `L2CP_A_EADDR: r_next.rdata = r_reg.eaddr;
          `L2CP_A_EMASK: r_next.rdata = 32'(r_reg.emask);
          `L2CP_A_SCTRL: r_next.rdata = r_reg.sctrl;
          `L2CP_A_SDLY:  r_next.rdata = 32'(r_reg.sdly);
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r_reg <= '0;
      r_reg.ctrl <= l2cp_pkg::l2cp_ctrl_t'(`L2CP_CTRL_RST);
      r_reg.sdly <= `L2CP_SDLY_RST;
      r_reg.lfsr <= `L2CP_LFSR_SEED;
    end else begin
      r_reg <= r_next;
    end
  end

  assign axi_out = '{awready: aw_go, wready: aw_go, bvalid: r_reg.bvalid,
    bresp: r_reg.bresp, arready: !r_reg.rvalid, rvalid: r_reg.rvalid,
    rdata: r_reg.rdata, rresp: r_reg.rresp};
  assign dec_out = r_reg.dec;
  assign ecc_out = r_reg.ecc;
  assign scrub_out = '{valid: r_reg.sst == l2cp_pkg::S_REQ,
    idx: r_reg.sidx, way: r_reg.sway};
  assign irq_out = |(r_reg.estat.pend & r_reg.emask);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_one_req;
    r_reg.sst == l2cp_pkg::S_REQ && r_reg.sone;
  endsequence
  sequence s_one_done;
    s_one_req ##0 scrub_done_in && !(aw_go &&
      axi_in.awaddr[7:0] == `L2CP_A_SCTRL);
  endsequence

  a_lru_reset: assert property ($fell(srst_in) |->
    r_reg.ctrl.repl == l2cp_pkg::REPL_LRU)
    else $error("Replacement policy not LRU after reset.");
  a_master_way: assert property (acc_in.valid && acc_in.mst < 4'h3 &&
    r_reg.ctrl.repl inside {l2cp_pkg::REPL_MFIX, l2cp_pkg::REPL_MMOD} |=>
    dec_out.way == 2'($past(acc_in.mst)) + 2'h1)
    else $error("Master did not replace way index plus one.");
  a_ovf_fixed: assert property (acc_in.valid &&
    r_reg.ctrl.repl == l2cp_pkg::REPL_MFIX && acc_in.mst >= 4'h3 |=>
    dec_out.way == $past(r_reg.ctrl.ovf_way))
    else $error("Overflow master ignored fixed way.");
  a_prot_demote: assert property (acc_in.valid &&
    r_reg.ctrl.hprot_en && !acc_in.hprot[`L2CP_HP_C] |=>
    !dec_out.cachable && !dec_out.alloc)
    else $error("Protection bits failed to demote access.");
  a_read_bypass: assert property (acc_in.valid && !acc_in.write &&
    hitu && !cach && acc_in.hprot[3:2] == 2'h0 && r_reg.ctrl.rhb &&
    !wp |=> dec_out.mem)
    else $error("Bypassed read hit did not go to memory.");
  a_flush_retry: assert property (acc_in.valid && flush_busy_in
    |=> dec_out.resp == l2cp_pkg::RSP_RETRY)
    else $error("Access during flush not retried.");
  a_ue_overwrite: assert property (ev_ue |=>
    r_reg.estat.valid && r_reg.estat.etype == l2cp_pkg::ET_UE &&
    r_reg.eaddr == $past(ecc_in.addr))
    else $error("Uncorrectable error not recorded.");
  a_ce_irq: assert property (ev_ce && r_reg.emask[0] |=> irq_out
    [*2])
    else $error("Correctable error raised no interrupt.");
  a_ue_read: assert property (e_ue && !ecc_in.is_tag && !ecc_in.write
    |=> ecc_out.act == l2cp_pkg::ACT_INVAL &&
    ecc_out.resp != l2cp_pkg::RSP_OK)
    else $error("Uncorrectable read not invalidated.");
  a_scrub_clear: assert property (s_one_done |=>
    !r_reg.sctrl.pend && !scrub_out.valid)
    else $error("Single scrub pending bit not cleared.");
endmodule : l2cp_top

// ==== testbench/l2cp_dp_model.sv ====
// Cache datapath stand-in that completes each scrub request.
// Assumes a request holds until its done pulse has been sampled.
`timescale 1ns/1ps
module l2cp_dp_model #(
  parameter int DLY = 3
) (
  input  wire logic                  clk_in,
  input  wire l2cp_pkg::l2cp_scrub_t scrub_in,
  output logic                       done_out
);
  int   n    = 0;
  logic d_reg = 1'b0;
  assign done_out = d_reg;
  always @(posedge clk_in) begin
    if (d_reg) begin
      d_reg <= 1'b0;
      n     <= 0;
    end else if (scrub_in.valid) begin
      n <= n + 1;
      if (n == DLY) begin
        d_reg <= 1'b1;
      end
    end
  end
endmodule : l2cp_dp_model

// ==== testbench/l2cp_top_tb.sv ====
// Self-checking bench of the cache policy block.
// Assumes the datapath model answers scrub requests.
`timescale 1ns/1ps
`include "l2cp_consts.svh"
module l2cp_top_tb;
  logic                    clk_in = 1'b0;
  logic                    srst_in = 1'b1;
  logic                    berr = 1'b0;
  logic [31:0]             baddr = 32'h0;
  logic                    fbusy = 1'b0;
  logic                    done;
  logic                    irq;
  l2cp_pkg::l2cp_axi_req_t a = '0;
  l2cp_pkg::l2cp_axi_rsp_t r;
  l2cp_pkg::l2cp_acc_req_t q = '0;
  l2cp_pkg::l2cp_acc_dec_t dec;
  l2cp_pkg::l2cp_ecc_req_t e = '0;
  l2cp_pkg::l2cp_ecc_res_t eo;
  l2cp_pkg::l2cp_scrub_t   sc;
  int                      mismatches = 0;
  int                      total_checks = 0;
  always #20 clk_in = ~clk_in;
  l2cp_top u_l2cp_top (.clk_in(clk_in), .srst_in(srst_in), .axi_in(a),
    .axi_out(r), .acc_in(q), .dec_out(dec), .ecc_in(e), .ecc_out(eo),
    .bus_err_in(berr), .bus_err_addr_in(baddr), .flush_busy_in(fbusy),
    .scrub_out(sc), .scrub_done_in(done), .irq_out(irq));
  l2cp_dp_model u_l2cp_dp_model (.clk_in(clk_in), .scrub_in(sc),
    .done_out(done));
  task automatic chk(input string n, input logic [31:0] x, g);
    total_checks++;
    if (g !== x) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk_in);
    a.awvalid <= 1'b1;
    a.wvalid  <= 1'b1;
    a.awaddr  <= ad;
    a.wdata   <= d;
    a.wstrb   <= 4'hf;
    a.bready  <= 1'b1;
    do @(posedge clk_in); while (!r.awready);
    a.awvalid <= 1'b0;
    a.wvalid  <= 1'b0;
    do @(posedge clk_in); while (!r.bvalid);
    a.bready  <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] ad, output logic [31:0] d,
                    output logic [1:0] rs);
    @(posedge clk_in);
    a.arvalid <= 1'b1;
    a.araddr  <= ad;
    a.rready  <= 1'b1;
    do @(posedge clk_in); while (!r.arready);
    a.arvalid <= 1'b0;
    do @(posedge clk_in); while (!r.rvalid);
    d  = r.rdata;
    rs = r.rresp;
    a.rready  <= 1'b0;
  endtask : rd
  task automatic rdc(input string n, input logic [11:0] ad,
                     input logic [31:0] x);
    logic [31:0] d;
    logic [1:0]  rs;
    rd(ad, d, rs);
    chk(n, x, d);
  endtask : rdc
  task automatic lk(input logic [3:0] m, hp, input logic [31:0] ad,
                    input logic w, input logic [1:0] lw);
    @(posedge clk_in);
    q.valid   <= 1'b1;
    q.mst     <= m;
    q.hprot   <= hp;
    q.addr    <= ad;
    q.write   <= w;
    q.lru_way <= lw;
    @(posedge clk_in);
    q.valid   <= 1'b0;
    @(negedge clk_in);
  endtask : lk
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  rs;
    rdc("ctrl", `L2CP_A_CTRL, 32'h0);
    rdc("sdly", `L2CP_A_SDLY, 32'h100);
    rd(12'h03c, d, rs);
    chk("unmapped", 32'h2, rs);
    $display("test reset done");
  endtask : t_reset
  task automatic t_repl();
    wr(`L2CP_A_CTRL, 32'h1);
    lk(4'h0, 4'h8, 32'h100, 1'b0, 2'h3);
    chk("lru", 32'h3, dec.way);
    wr(`L2CP_A_CTRL, 32'h401);
    lk(4'h0, 4'h8, 32'h100, 1'b0, 2'h3);
    chk("lock", 32'h2, dec.way);
    wr(`L2CP_A_CTRL, 32'hc41);
    lk(4'h0, 4'h8, 32'h100, 1'b0, 2'h3);
    chk("rand", 32'h0, dec.way);
    wr(`L2CP_A_CTRL, 32'h281);
    for (int m = 0; m < 3; m++) begin
      lk(m[3:0], 4'h8, 32'h100, 1'b0, 2'h0);
      chk("mway", m + 1, dec.way);
    end
    lk(4'h5, 4'h8, 32'h100, 1'b0, 2'h0);
    chk("ovf", 32'h2, dec.way);
    wr(`L2CP_A_CTRL, 32'hc1);
    lk(4'h5, 4'h8, 32'h100, 1'b0, 2'h0);
    chk("mod", 32'h1, dec.way);
    $display("test repl done");
  endtask : t_repl
  task automatic t_prot();
    wr(`L2CP_A_CTRL, 32'hd);
    lk(4'h0, 4'h8, 32'h100, 1'b0, 2'h0);
    chk("alloc", 32'h3, {dec.alloc, dec.mem});
    chk("tag", 32'h300, dec.new_tag);
    lk(4'h0, 4'h0, 32'h100, 1'b0, 2'h0);
    chk("nc", 32'h1, {dec.cachable, dec.alloc, dec.mem});
    @(posedge clk_in);
    q.hit <= 1'b1;
    q.vd0 <= 4'h5;
    q.vd1 <= 4'h3;
    q.vd2 <= 4'h6;
    lk(4'h0, 4'h0, 32'h100, 1'b0, 2'h0);
    chk("bypass", 32'h1, dec.mem);
    chk("vote", 32'h7, dec.vd);
    @(posedge clk_in);
    q.hit <= 1'b0;
    lk(4'h0, 4'h8, 32'h8000_0100, 1'b0, 2'h0);
    chk("hi", 32'h0, dec.cachable);
    lk(4'h0, 4'h8, 32'hf080_0000, 1'b0, 2'h0);
    chk("win", 32'h2, dec.win);
    wr(`L2CP_A_CTRL, 32'h4);
    wr(12'h040, 32'h0002_fffd);
    wr(`L2CP_A_CTRL, 32'h15);
    lk(4'h0, 4'h8, 32'h100, 1'b1, 2'h0);
    chk("wp", 32'h1, dec.resp);
    chk("wt", 32'h1, dec.wt);
    @(posedge clk_in);
    fbusy <= 1'b1;
    lk(4'h0, 4'h8, 32'h100, 1'b0, 2'h0);
    chk("retry", 32'h2, dec.resp);
    @(posedge clk_in);
    fbusy <= 1'b0;
    $display("test prot done");
  endtask : t_prot
  task automatic t_err();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_in);
      berr  <= 1'b1;
      baddr <= i ? 32'habc : 32'h1234_5678;
      @(posedge clk_in);
      berr  <= 1'b0;
      rdc("estat", `L2CP_A_ESTAT, 32'h78);
      rdc("eaddr", `L2CP_A_EADDR, 32'h1234_5678);
    end
    chk("irq0", 32'h0, irq);
    wr(`L2CP_A_EMASK, 32'h8);
    @(negedge clk_in);
    chk("irq1", 32'h1, irq);
    wr(`L2CP_A_ESTAT, 32'h48);
    @(negedge clk_in);
    chk("irq2", 32'h0, irq);
    $display("test err done");
  endtask : t_err
  task automatic t_scrub();
    logic [31:0] d;
    logic [1:0]  rs;
    wr(`L2CP_A_SDLY, 32'h2);
    wr(`L2CP_A_SCTRL, 32'h0005_0009);
    do @(posedge clk_in); while (!sc.valid);
    chk("sline", 32'h0005_0002, {sc.idx, 14'h0, sc.way});
    do @(posedge clk_in); while (sc.valid);
    rd(`L2CP_A_SCTRL, d, rs);
    chk("spend", 32'h0, d[0]);
    wr(`L2CP_A_SCTRL, 32'h2);
    do @(posedge clk_in); while (!sc.valid);
    chk("loop0", 32'h0005_0002, {sc.idx, 14'h0, sc.way});
    do @(posedge clk_in); while (sc.valid);
    do @(posedge clk_in); while (!sc.valid);
    chk("loop1", 32'h0005_0003, {sc.idx, 14'h0, sc.way});
    wr(`L2CP_A_SCTRL, 32'h0);
    do @(posedge clk_in); while (sc.valid);
    $display("test scrub done");
  endtask : t_scrub
  task automatic ek(input logic [31:0] ad, d, input logic dt);
    @(posedge clk_in);
    e.valid <= 1'b1;
    e.addr  <= ad;
    e.data  <= d;
    e.dirty <= dt;
    @(posedge clk_in);
    e.valid <= 1'b0;
    @(negedge clk_in);
  endtask : ek
  task automatic t_ecc();
    wr(`L2CP_A_CTRL, 32'h3);
    wr(`L2CP_A_EMASK, 32'h9);
    ek(32'h40, 32'h1, 1'b1);
    chk("ce", 32'h1, {eo.chk, eo.act});
    chk("cdata", 32'h0, eo.data);
    chk("irq3", 32'h1, irq);
    ek(32'h80, 32'h3, 1'b1);
    chk("ue", 32'h9, {eo.act, eo.resp});
    rdc("eaddr2", `L2CP_A_EADDR, 32'h80);
    rdc("estat2", `L2CP_A_ESTAT, 32'h0100_0057);
    $display("test ecc done");
  endtask : t_ecc
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (5000) @(posedge clk_in);
    mismatches++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge clk_in);
    srst_in <= 1'b0;
    t_reset();
    t_repl();
    t_err();
    t_prot();
    t_ecc();
    t_scrub();
    close_out();
  end
endmodule : l2cp_top_tb
